/* hdl/ccd_map.vh */
// constants for the call, clear and decrement execution block
`ifndef CCD_MAP_VH
`define CCD_MAP_VH
`define CCD_OP_W 14
`define CCD_PC_W 13
`define CCD_CALL_TOP 3'h4
`define CCD_CLEAR_WORK_REG_OP_OP 14'h0103
`define CCD_WATCHDOG_CLEAR_OP_OP 14'h0064
`define CCD_DECREMENT_FILE_OP_TOP 6'h03
`define CCD_DEST_BIT 7
`define CCD_LATCH_HI 4
`define CCD_LATCH_LO 3
`define CCD_PC_RST 13'h0000
`define CCD_W_RST 8'h00
`define CCD_WDT_RST 8'h00
`define CCD_PRE_RST 8'h00
`endif

/* hdl/ccd_decode.v */
// opcode classifier for the call, clear and decrement instructions
`timescale 1ns/1ps
`include "ccd_map.vh"
module ccd_decode (
    input wire [13:0] opcode,
    output wire is_call,
    output wire is_clear_work_reg_op,
    output wire is_watchdog_clear_op,
    output wire is_decrement_file_op
);
    assign is_call = (opcode[13:11] == `CCD_CALL_TOP); // RQ2
    assign is_clear_work_reg_op = (opcode == `CCD_CLEAR_WORK_REG_OP_OP); // RQ5
    assign is_watchdog_clear_op = (opcode == `CCD_WATCHDOG_CLEAR_OP_OP); // RQ6
    assign is_decrement_file_op = (opcode[13:8] == `CCD_DECREMENT_FILE_OP_TOP); // RQ9
endmodule

/* hdl/ccd_core.v */
// execution core for call, clear-w, watchdog-clear and decrement
// Functional notes
// RQ1 - call pushes pc plus one onto the stack top before jumping
// RQ2 - call opcode is 100 prefix; 11-bit literal loads pc bits 10 to 0
// RQ3 - call takes pc bits 12:11 from page latch bits 4:3; no flags change
// RQ4 - call is one word and two instruction cycles
// RQ5 - clear-w opcode zeroes the working register and sets zero flag
// RQ6 - watchdog-clear opcode zeroes the watchdog counter in one cycle
// RQ7 - watchdog-clear also zeroes the watchdog prescaler
// RQ8 - watchdog-clear sets timeout and powerdown status bits, nothing else
// RQ9 - decrement file register, result to w or file by dest bit, update zero
// RQ10 - two-cycle transfers flush the prefetched word and run an idle cycle
`timescale 1ns/1ps
`include "ccd_map.vh"
module ccd_core (
    input wire CLK_SYS,
    input wire RST_N,
    input wire INSTR_VALID,
    input wire [13:0] INSTR,
    input wire [7:0] PROGRAM_PAGE_LATCH,
    input wire [7:0] FILE_RDATA,
    input wire WDT_TICK,
    output reg [12:0] PC,
    output reg [12:0] STACK_TOP,
    output reg STACK_PUSH,
    output reg [7:0] WORK_REG,
    output reg ZERO_FLAG,
    output reg TIMEOUT_STATUS_N,
    output reg POWERDOWN_STATUS_N,
    output reg [7:0] WATCHDOG_COUNTER,
    output reg [7:0] WDT_PRESCALER,
    output reg [6:0] FILE_ADDR,
    output reg [7:0] FILE_WDATA,
    output reg FILE_WE,
    output reg IDLE_CYCLE
);
    localparam ST_EXEC = 2'b01;
    localparam ST_IDLE = 2'b10;

    // decoder strobes
    wire is_call;
    wire is_clear_work_reg_op;
    wire is_watchdog_clear_op;
    wire is_decrement_file_op;

    // sequencer
    reg [1:0] state_reg;
    reg [1:0] state_next;

    // next values of the output flip-flops
    reg [12:0] pc_next;
    reg [12:0] stack_top_next;
    reg stack_push_next;
    reg idle_cycle_next;
    reg [7:0] work_reg_next;
    reg zero_flag_next;
    reg [6:0] file_addr_next;
    reg [7:0] file_wdata_next;
    reg file_we_next;
    reg [7:0] wdt_prescaler_next;
    reg [7:0] watchdog_counter_next;
    reg timeout_status_n_next;
    reg powerdown_status_n_next;

    // execution qualifiers
    wire take_instr;
    wire [7:0] dec_result;
    wire [12:0] return_addr;
    wire [12:0] call_target;
    wire prescaler_wrap;

    function [12:0] pc_inc;
        input [12:0] p;
        begin
            pc_inc = p + 13'h0001;
        end
    endfunction

    function [7:0] inc8;
        input [7:0] v;
        begin
            inc8 = v + 8'h01;
        end
    endfunction

    function is_zero8;
        input [7:0] v;
        begin
            is_zero8 = (v == 8'h00);
        end
    endfunction

    // the word after a call is flushed, so only the exec state takes one
    assign take_instr = INSTR_VALID && (state_reg != ST_IDLE); // RQ10
    assign dec_result = FILE_RDATA - 8'h01; // RQ9
    assign return_addr = pc_inc(PC); // RQ1
    assign call_target = {PROGRAM_PAGE_LATCH[`CCD_LATCH_HI:`CCD_LATCH_LO], INSTR[10:0]}; // RQ2 RQ3
    assign prescaler_wrap = WDT_TICK && (WDT_PRESCALER == 8'hFF);

    ccd_decode ccd_decode_i (
        .opcode(INSTR),
        .is_call(is_call),
        .is_clear_work_reg_op(is_clear_work_reg_op),
        .is_watchdog_clear_op(is_watchdog_clear_op),
        .is_decrement_file_op(is_decrement_file_op)
    );

    always @*
    begin
        state_next = ST_EXEC;
        case (state_reg)
            ST_EXEC:
            begin
                if (INSTR_VALID && is_call)
                    state_next = ST_IDLE; // RQ4
            end
            ST_IDLE:
                state_next = ST_EXEC;
            default:
                state_next = ST_EXEC;
        endcase
    end

    // program flow: call target, return address, idle slot
    always @*
    begin
        pc_next = PC;
        stack_top_next = STACK_TOP;
        stack_push_next = 1'b0;
        idle_cycle_next = 1'b0;
        if (state_reg == ST_IDLE)
        begin
            idle_cycle_next = 1'b1; // RQ10
        end
        else if (INSTR_VALID)
        begin
            if (is_call)
            begin
                stack_top_next = return_addr; // RQ1
                stack_push_next = 1'b1; // RQ1
                pc_next = call_target; // RQ2 RQ3
            end
            else
            begin
                pc_next = pc_inc(PC);
            end
        end
    end

    // working register and zero flag; call leaves the flags alone
    always @*
    begin
        work_reg_next = WORK_REG;
        zero_flag_next = ZERO_FLAG;
        if (take_instr)
        begin
            if (is_clear_work_reg_op)
            begin
                work_reg_next = 8'h00; // RQ5
                zero_flag_next = 1'b1; // RQ5
            end
            else if (is_decrement_file_op)
            begin
                zero_flag_next = is_zero8(dec_result); // RQ9
                if (!INSTR[`CCD_DEST_BIT])
                begin
                    work_reg_next = dec_result; // RQ9
                end
            end
        end
    end

    // file register write port
    always @*
    begin
        file_addr_next = INSTR[6:0];
        file_wdata_next = FILE_WDATA;
        file_we_next = 1'b0;
        if (take_instr && is_decrement_file_op && INSTR[`CCD_DEST_BIT])
        begin
            file_wdata_next = dec_result; // RQ9
            file_we_next = 1'b1; // RQ9
        end
    end

    // watchdog prescaler, counter and status; a clear beats a tick
    always @*
    begin
        wdt_prescaler_next = WDT_PRESCALER;
        watchdog_counter_next = WATCHDOG_COUNTER;
        timeout_status_n_next = TIMEOUT_STATUS_N;
        powerdown_status_n_next = POWERDOWN_STATUS_N;
        if (WDT_TICK)
        begin
            wdt_prescaler_next = inc8(WDT_PRESCALER);
        end
        if (prescaler_wrap)
        begin
            watchdog_counter_next = inc8(WATCHDOG_COUNTER);
        end
        if (take_instr && is_watchdog_clear_op)
        begin
            watchdog_counter_next = `CCD_WDT_RST; // RQ6
            wdt_prescaler_next = `CCD_PRE_RST; // RQ7
            timeout_status_n_next = 1'b1; // RQ8
            powerdown_status_n_next = 1'b1; // RQ8
        end
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= ST_EXEC;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PC <= `CCD_PC_RST;
            STACK_TOP <= `CCD_PC_RST;
            STACK_PUSH <= 1'b0;
            IDLE_CYCLE <= 1'b0;
        end
        else
        begin
            PC <= pc_next;
            STACK_TOP <= stack_top_next;
            STACK_PUSH <= stack_push_next;
            IDLE_CYCLE <= idle_cycle_next;
        end
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            WORK_REG <= `CCD_W_RST;
            ZERO_FLAG <= 1'b0;
        end
        else
        begin
            WORK_REG <= work_reg_next;
            ZERO_FLAG <= zero_flag_next;
        end
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            FILE_ADDR <= 7'h00;
            FILE_WDATA <= 8'h00;
            FILE_WE <= 1'b0;
        end
        else
        begin
            FILE_ADDR <= file_addr_next;
            FILE_WDATA <= file_wdata_next;
            FILE_WE <= file_we_next;
        end
    end

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            WDT_PRESCALER <= `CCD_PRE_RST;
            WATCHDOG_COUNTER <= `CCD_WDT_RST;
            TIMEOUT_STATUS_N <= 1'b1;
            POWERDOWN_STATUS_N <= 1'b1;
        end
        else
        begin
            WDT_PRESCALER <= wdt_prescaler_next;
            WATCHDOG_COUNTER <= watchdog_counter_next;
            TIMEOUT_STATUS_N <= timeout_status_n_next;
            POWERDOWN_STATUS_N <= powerdown_status_n_next;
        end
    end
endmodule

/* sim/ccd_core_properties.sv */
// assertions for the call, clear and decrement core
`timescale 1ns/1ps
module ccd_core_properties (
    input wire CLK_SYS,
    input wire RST_N,
    input wire INSTR_VALID,
    input wire STACK_PUSH,
    input wire ZERO_FLAG,
    input wire IDLE_CYCLE,
    input wire FILE_WE,
    input wire TIMEOUT_STATUS_N,
    input wire POWERDOWN_STATUS_N,
    input wire [13:0] INSTR,
    input wire [12:0] PC,
    input wire [12:0] STACK_TOP,
    input wire [7:0] PROGRAM_PAGE_LATCH,
    input wire [7:0] FILE_RDATA,
    input wire [7:0] WORK_REG,
    input wire [7:0] FILE_WDATA,
    input wire [7:0] WATCHDOG_COUNTER,
    input wire [7:0] WDT_PRESCALER,
    input wire [6:0] FILE_ADDR
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire tk = INSTR_VALID && !STACK_PUSH;
    wire wd = tk && INSTR == 14'h0064;
    sequence s_call; tk && INSTR[13:11] == 3'h4; endsequence
    sequence s_idle; IDLE_CYCLE && $stable(PC); endsequence
    property p_push; s_call |=> STACK_PUSH && STACK_TOP == $past(PC) + 13'h1; endproperty
    a_push: assert property (p_push) else $error("push");
    property p_jump; s_call |=> PC == {$past(PROGRAM_PAGE_LATCH[4:3]), $past(INSTR[10:0])};
    endproperty
    a_jump: assert property (p_jump) else $error("jump");
    property p_flag; s_call |=> $stable(ZERO_FLAG) && $stable(TIMEOUT_STATUS_N)
        && $stable(POWERDOWN_STATUS_N); endproperty
    a_flag: assert property (p_flag) else $error("flag");
    property p_idle; s_call |=> !IDLE_CYCLE ##1 s_idle; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_clear_work_reg_op; tk && INSTR == 14'h0103 |=> WORK_REG == 8'h00 && ZERO_FLAG; endproperty
    a_clear_work_reg_op: assert property (p_clear_work_reg_op) else $error("clear_work_reg_op");
    property p_wdt; wd |=> WATCHDOG_COUNTER == 8'h00 && WDT_PRESCALER == 8'h00; endproperty
    a_wdt: assert property (p_wdt) else $error("wdt");
    property p_stat; wd |=> TIMEOUT_STATUS_N && POWERDOWN_STATUS_N && $stable(ZERO_FLAG);
    endproperty
    a_stat: assert property (p_stat) else $error("stat");
    property p_dec; tk && INSTR[13:8] == 6'h03 |=> ZERO_FLAG == ($past(FILE_RDATA) == 8'h01)
        && ($past(INSTR[7]) ? FILE_WE && FILE_WDATA == $past(FILE_RDATA) - 8'h01
        : WORK_REG == $past(FILE_RDATA) - 8'h01); endproperty
    a_dec: assert property (p_dec) else $error("dec");
    property p_addr; INSTR_VALID |=> FILE_ADDR == $past(INSTR[6:0]); endproperty
    a_addr: assert property (p_addr) else $error("addr");
endmodule
bind ccd_core ccd_core_properties ccd_core_properties_i (.*);

/* sim/ccd_core_tb.sv */
// bench for the call, clear and decrement core
`timescale 1ns/1ps
module ccd_core_tb;
    logic CLK_SYS = 1'b0, RST_N = 1'b0, INSTR_VALID = 1'b0, WDT_TICK = 1'b0;
    logic [13:0] INSTR = 14'h0000;
    logic [7:0] PROGRAM_PAGE_LATCH = 8'h18, FILE_RDATA = 8'h10;
    logic [12:0] PC, STACK_TOP;
    logic [7:0] WORK_REG, WATCHDOG_COUNTER, WDT_PRESCALER, FILE_WDATA;
    logic [6:0] FILE_ADDR;
    logic STACK_PUSH, ZERO_FLAG, TIMEOUT_STATUS_N, POWERDOWN_STATUS_N, FILE_WE, IDLE_CYCLE;
    int err_count = 0, n_compared = 0;
    ccd_core ccd_core_i (
        .CLK_SYS(CLK_SYS),
        .RST_N(RST_N),
        .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR),
        .PROGRAM_PAGE_LATCH(PROGRAM_PAGE_LATCH),
        .FILE_RDATA(FILE_RDATA),
        .WDT_TICK(WDT_TICK),
        .PC(PC),
        .STACK_TOP(STACK_TOP),
        .STACK_PUSH(STACK_PUSH),
        .WORK_REG(WORK_REG),
        .ZERO_FLAG(ZERO_FLAG),
        .TIMEOUT_STATUS_N(TIMEOUT_STATUS_N),
        .POWERDOWN_STATUS_N(POWERDOWN_STATUS_N),
        .WATCHDOG_COUNTER(WATCHDOG_COUNTER),
        .WDT_PRESCALER(WDT_PRESCALER),
        .FILE_ADDR(FILE_ADDR),
        .FILE_WDATA(FILE_WDATA),
        .FILE_WE(FILE_WE),
        .IDLE_CYCLE(IDLE_CYCLE)
    );
    always #12.5 CLK_SYS = ~CLK_SYS;
    task ex(input logic v, input logic [13:0] i, input logic [7:0] f = 8'h10);
        @(posedge CLK_SYS);
        INSTR_VALID <= v;
        INSTR <= i;
        FILE_RDATA <= f;
        #1;
    endtask
    task chk(input logic [12:0] g, input logic [12:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task conclude;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_count++;
        conclude;
    end
    initial
    begin
        repeat (10) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        WDT_TICK <= 1'b1;
        #1;
        chk(TIMEOUT_STATUS_N, 1);
        ex(1, 14'h0303);
        ex(1, 14'h2555);
        chk(WORK_REG, 8'h0F);
        ex(1, 14'h0103);
        chk(PC, 13'h1D55);
        chk(STACK_TOP, 13'h0002);
        chk(STACK_PUSH, 1);
        ex(1, 14'h0383);
        chk(IDLE_CYCLE, 1);
        chk(ZERO_FLAG, 0);
        ex(1, 14'h0103);
        chk(FILE_WDATA, 8'h0F);
        chk(FILE_WE, 1);
        chk(FILE_ADDR, 7'h03);
        ex(1, 14'h0064);
        chk(ZERO_FLAG, 1);
        chk(WORK_REG, 8'h00);
        ex(0, 14'h0000);
        chk(WDT_PRESCALER, 8'h00);
        chk(WATCHDOG_COUNTER, 8'h00);
        chk(POWERDOWN_STATUS_N, 1);
        repeat (256) @(posedge CLK_SYS);
        #1;
        chk(WATCHDOG_COUNTER, 8'h01);
        chk(WDT_PRESCALER, 8'h00);
        ex(1, 14'h0303);
        ex(1, 14'h0303, 8'h01);
        chk(ZERO_FLAG, 0);
        chk(WORK_REG, 8'h0F);
        ex(0, 14'h0000);
        chk(WORK_REG, 8'h00);
        chk(ZERO_FLAG, 1);
        conclude;
    end
endmodule
